// ---- pkg/bbw_pkg.sv ----
package bbw_pkg;

  // time base
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned TICK_CYC        = CLK_HZ;
  localparam logic [24:0] TICK_LAST       = 25'(TICK_CYC - 1);
  localparam logic [7:0]  BOOT_TIMEOUT_S  = 8'd180;
  localparam logic [7:0]  SEC_ZERO        = 8'h00;

  // timer use and expiry action encodings
  localparam logic [2:0]  USE_BIOS        = 3'h1;
  localparam logic [2:0]  USE_OS          = 3'h3;
  localparam logic [1:0]  ACT_NONE        = 2'h0;
  localparam logic [1:0]  ACT_HARD_RESET  = 2'h1;
  localparam logic [1:0]  ACT_POWER_DOWN  = 2'h2;
  localparam logic [1:0]  ACT_POWER_CYCLE = 2'h3;

  // sensor identities
  localparam logic [7:0]  WDT_SNS_TYPE    = 8'h23;
  localparam logic [7:0]  WDT_SNS_EVT     = 8'h6f;
  localparam logic [7:0]  WDT_SNS_NUM     = 8'h04;
  localparam logic [7:0]  HLT_SNS_TYPE    = 8'hc0;
  localparam logic [7:0]  HLT_SNS_EVT     = 8'h70;
  localparam logic [7:0]  HLT_SNS_NUM     = 8'h09;
  localparam logic [7:0]  HLT_BYTE1       = 8'ha0;
  localparam logic [7:0]  HLT_COMP_BIOS   = 8'h03;
  localparam logic [7:0]  HLT_FLASH0_FAIL = 8'h29;
  localparam logic [7:0]  HLT_FLASH1_FAIL = 8'h31;
  localparam logic [7:0]  WDT_OFF_HARD    = 8'h01;

  // event log geometry
  localparam int unsigned LOG_RECORDS     = 4096;
  localparam int unsigned LOG_REC_BYTES   = 16;
  localparam int unsigned LOG_BYTES       = LOG_RECORDS * LOG_REC_BYTES;
  localparam logic [11:0] LOG_IDX_LAST    = 12'hfff;
  localparam logic [15:0] LOG_BASE        = 16'h0000;
  localparam logic        MODE_STOP       = 1'b0;
  localparam logic        MODE_WRAP       = 1'b1;

  typedef enum logic [2:0] {
    ST_OFF, ST_RUN, ST_SWAP, ST_RESET, ST_REARM
  } bbw_state_type;

  typedef enum logic [1:0] {
    EV_IDLE, EV_TIMEOUT, EV_FAILOVER
  } bbw_evsrc_type;

endpackage : bbw_pkg

// ---- hw/bbw_watchdog.sv ----
`timescale 1ns/1ns
// What this block does
// - arming loads 180 second timeout
// - count starts at payload power on
// - default action hard reset, use bios
// - expiry with hard reset and use bios: swap flash, reset, then re-arm
// - endless loop; log timeout and failover
// - host may change action; power down and power cycle only pulse reset
// - log is 4096 records of 16 bytes
// - log takes internal and host events
// - records live in external spi flash
// - every event forwarded to event receiver
// - watchdog sensor 23h/6fh number 4
// - health sensor c0h/70h number 9
// - health data a0, component, failed flash
// - mode 0 stops when full, 1 wraps
// - mode change erases the log
module bbw_watchdog
  import bbw_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  // payload power pin
  input  wire logic        pay_pwr_i,
  // host timer control
  input  wire logic        host_stop_i,
  input  wire logic        host_cfg_i,
  input  wire logic [1:0]  host_act_i,
  input  wire logic [2:0]  host_use_i,
  // host event in
  input  wire logic        hev_valid_i,
  input  wire logic [7:0]  hev_type_i,
  input  wire logic [7:0]  hev_evt_i,
  input  wire logic [7:0]  hev_num_i,
  input  wire logic [23:0] hev_data_i,
  // log policy
  input  wire logic        log_mode_i,
  // flash writer handshake
  input  wire logic        fl_ready_i,
  // outputs
  output logic             bios_sel_o,
  output logic             sys_reset_o,
  output logic             running_o,
  output logic [7:0]       secs_left_o,
  output logic [1:0]       action_o,
  output logic [2:0]       timer_use_o,
  output logic             fl_write_o,
  output logic             fl_erase_o,
  output logic [15:0]      fl_addr_o,
  output logic [127:0]     fl_data_o,
  output logic             log_full_o,
  output logic             evr_valid_o,
  output logic [127:0]     evr_data_o
);

  typedef struct packed {
    logic [1:0]    pwr_sync;
    logic          pwr_seen;
    bbw_state_type st;
    logic [24:0]   tick;
    logic [7:0]    secs;
    logic [1:0]    act;
    logic [2:0]    use_f;
    logic          sel;
    logic          rst;
    logic          pend_to;
    logic          pend_fo;
    logic          mode;
    logic          mode_ok;
    logic [11:0]   widx;
    logic [12:0]   count;
    logic          fl_wr;
    logic          fl_er;
    logic [15:0]   fl_addr;
    logic [127:0]  fl_data;
    logic          evr_v;
    logic [127:0]  evr_d;
    logic          run;
    logic          full;
  } bbw_regs_type;

  bbw_regs_type st_r;
  bbw_regs_type st_nxt;

  // record: type, evtype, number, three data bytes, rest zero padding
  function automatic logic [127:0] mk_rec(input logic [7:0]  t,
                                          input logic [7:0]  e,
                                          input logic [7:0]  n,
                                          input logic [23:0] d);
    mk_rec = {t, e, n, d, 80'h0};
  endfunction : mk_rec

  always_comb begin
    logic          have;
    logic [127:0]  rec;
    logic          pwr;
    have   = 1'b0;
    rec    = '0;
    st_nxt = st_r;
    st_nxt.pwr_sync = {st_r.pwr_sync[0], pay_pwr_i};
    pwr    = st_r.pwr_sync[1];
    st_nxt.pwr_seen = pwr;
    st_nxt.rst   = 1'b0;
    st_nxt.fl_er = 1'b0;
    st_nxt.evr_v = 1'b0;
    if (st_r.fl_wr && fl_ready_i) begin
      st_nxt.fl_wr = 1'b0;
    end
    if (!st_r.mode_ok) begin
      // first mode sample after reset adopts the strap without erasing
      st_nxt.mode    = log_mode_i;
      st_nxt.mode_ok = 1'b1;
    end else if (log_mode_i != st_r.mode) begin
      st_nxt.mode  = log_mode_i;
      st_nxt.widx  = '0;
      st_nxt.count = '0;
      st_nxt.fl_er = 1'b1;
    end
    case (st_r.st)
      ST_OFF: begin
        if (pwr && !st_r.pwr_seen) begin
          st_nxt.st    = ST_RUN;
          st_nxt.secs  = BOOT_TIMEOUT_S;
          st_nxt.tick  = '0;
          st_nxt.act   = ACT_HARD_RESET;
          st_nxt.use_f = USE_BIOS;
        end
      end
      ST_RUN: begin
        if (!pwr || host_stop_i) begin
          st_nxt.st = ST_OFF;
        end else begin
          if (host_cfg_i) begin
            st_nxt.act   = host_act_i;
            st_nxt.use_f = host_use_i;
          end
          if (st_r.tick == TICK_LAST) begin
            st_nxt.tick = '0;
            st_nxt.secs = st_r.secs - 8'd1;
            if (st_r.secs == 8'd1) begin
              st_nxt.pend_to = 1'b1;
              st_nxt.st = (st_r.act == ACT_HARD_RESET && st_r.use_f == USE_BIOS)
                          ? ST_SWAP : ST_OFF;
              // any other armed action resets the host but keeps the flash select
              if (st_r.act != ACT_NONE &&
                  !(st_r.act == ACT_HARD_RESET && st_r.use_f == USE_BIOS)) begin
                st_nxt.rst = 1'b1;
              end
            end
          end else begin
            st_nxt.tick = st_r.tick + 25'd1;
          end
        end
      end
      ST_SWAP: begin
        st_nxt.sel     = ~st_r.sel;
        st_nxt.pend_fo = 1'b1;
        st_nxt.st      = ST_RESET;
      end
      ST_RESET: begin
        st_nxt.rst = 1'b1;
        st_nxt.st  = ST_REARM;
      end
      default: begin
        st_nxt.st    = pwr ? ST_RUN : ST_OFF;
        st_nxt.secs  = BOOT_TIMEOUT_S;
        st_nxt.tick  = '0;
        st_nxt.act   = ACT_HARD_RESET;
        st_nxt.use_f = USE_BIOS;
      end
    endcase
    // one event per cycle: host events first, then timeout, then failover
    if (hev_valid_i) begin
      have = 1'b1;
      rec  = mk_rec(hev_type_i, hev_evt_i, hev_num_i, hev_data_i);
    end else if (st_r.pend_to) begin
      have = 1'b1;
      st_nxt.pend_to = 1'b0;
      rec  = mk_rec(WDT_SNS_TYPE, WDT_SNS_EVT, WDT_SNS_NUM,
                    {WDT_OFF_HARD, 16'h0});
    end else if (st_r.pend_fo) begin
      have = 1'b1;
      st_nxt.pend_fo = 1'b0;
      rec  = mk_rec(HLT_SNS_TYPE, HLT_SNS_EVT, HLT_SNS_NUM,
                    {HLT_BYTE1, HLT_COMP_BIOS,
                     st_r.sel ? HLT_FLASH0_FAIL : HLT_FLASH1_FAIL});
    end
    if (have) begin
      st_nxt.evr_v = 1'b1;
      st_nxt.evr_d = rec;
      // a busy flash writer or a full stop-mode log drops only the local copy
      if (!st_r.fl_wr && !st_nxt.fl_er &&
          (st_r.mode == MODE_WRAP || st_r.count != 13'(LOG_RECORDS))) begin
        st_nxt.fl_wr   = 1'b1;
        st_nxt.fl_addr = LOG_BASE + {st_r.widx, 4'h0};
        st_nxt.fl_data = rec;
        st_nxt.widx    = st_r.widx + 12'd1;
        if (st_r.count != 13'(LOG_RECORDS)) begin
          st_nxt.count = st_r.count + 13'd1;
        end
      end
    end
    // status outputs registered so they leave the block glitch free
    st_nxt.run  = (st_nxt.st == ST_RUN);
    st_nxt.full = (st_nxt.count == 13'(LOG_RECORDS));
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= '{st: ST_OFF, act: ACT_HARD_RESET, use_f: USE_BIOS,
                secs: SEC_ZERO, mode: MODE_STOP, default: '0};
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign bios_sel_o  = st_r.sel;
  assign sys_reset_o = st_r.rst;
  assign running_o   = st_r.run;
  assign secs_left_o = st_r.secs;
  assign action_o    = st_r.act;
  assign timer_use_o = st_r.use_f;
  assign fl_write_o  = st_r.fl_wr;
  assign fl_erase_o  = st_r.fl_er;
  assign fl_addr_o   = st_r.fl_addr;
  assign fl_data_o   = st_r.fl_data;
  assign log_full_o  = st_r.full;
  assign evr_valid_o = st_r.evr_v;
  assign evr_data_o  = st_r.evr_d;

endmodule : bbw_watchdog

// ---- sim/bbw_props.sv ----
`timescale 1ns/1ns
module bbw_props
  import bbw_pkg::*;
(
  // clock, reset and inputs
  input wire logic         mclk_i,
  input wire logic         rstn_i,
  input wire logic         ce_i,
  input wire logic         hev_valid_i,
  input wire logic         log_mode_i,
  input wire logic         fl_ready_i,
  // outputs
  input wire logic         bios_sel_o,
  input wire logic         sys_reset_o,
  input wire logic         running_o,
  input wire logic [7:0]   secs_left_o,
  input wire logic         fl_write_o,
  input wire logic [15:0]  fl_addr_o,
  input wire logic         fl_erase_o,
  input wire logic         evr_valid_o,
  input wire logic [127:0] evr_data_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  a_reset_pulse: assert property (sys_reset_o |=> !sys_reset_o)
    else $error("system reset longer than one cycle");
  a_write_hold: assert property (fl_write_o && !fl_ready_i |=> fl_write_o && $stable(fl_addr_o))
    else $error("flash write dropped before ready");
  a_evr_fwd: assert property (hev_valid_i && ce_i |=> evr_valid_o)
    else $error("event not forwarded");
  a_mode_erase: assert property ($changed(log_mode_i) |-> ##[1:2] fl_erase_o)
    else $error("no erase after mode change");
  a_sel_cause: assert property ($changed(bios_sel_o) |-> $past(secs_left_o) == SEC_ZERO)
    else $error("flash select moved without expiry");
  a_arm_full: assert property ($rose(running_o) |-> secs_left_o == BOOT_TIMEOUT_S)
    else $error("timer started without full load");
  a_sec_step: assert property (running_o && $past(running_o) && secs_left_o != $past(secs_left_o)
    |-> secs_left_o == $past(secs_left_o) - 8'h01)
    else $error("seconds count not stepping by one");
  a_rec_pad: assert property (evr_valid_o |-> evr_data_o[79:0] == 80'h0)
    else $error("record padding not zero");
  c_write: cover property (fl_write_o && fl_ready_i);
  c_erase: cover property (fl_erase_o);
  c_arm: cover property ($rose(running_o));
endmodule : bbw_props

bind bbw_watchdog bbw_props i_props (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
  .hev_valid_i(hev_valid_i), .log_mode_i(log_mode_i), .fl_ready_i(fl_ready_i),
  .bios_sel_o(bios_sel_o), .sys_reset_o(sys_reset_o), .running_o(running_o),
  .secs_left_o(secs_left_o), .fl_write_o(fl_write_o), .fl_addr_o(fl_addr_o),
  .fl_erase_o(fl_erase_o), .evr_valid_o(evr_valid_o), .evr_data_o(evr_data_o));

// ---- sim/bbw_host_model.sv ----
`timescale 1ns/1ns
module bbw_host_model
  import bbw_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  // bench control
  input  wire logic [2:0] lat_i,
  input  wire logic       boot_done_i,
  // device side
  input  wire logic       fl_write_i,
  output logic            fl_ready_o,
  output logic            host_stop_o
);
  logic [2:0] cnt_r;
  // ready never idles high, so a slow writer really holds the device off
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r       <= 3'h0;
      fl_ready_o  <= 1'b0;
      host_stop_o <= 1'b0;
    end else begin
      host_stop_o <= boot_done_i;
      if (fl_write_i && !fl_ready_o) begin
        cnt_r      <= cnt_r + 3'h1;
        fl_ready_o <= (cnt_r >= lat_i);
      end else begin
        cnt_r      <= 3'h0;
        fl_ready_o <= 1'b0;
      end
    end
  end
endmodule : bbw_host_model

// ---- sim/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  import bbw_pkg::*;
  typedef struct {logic [7:0] t, e, n; logic [23:0] d; logic [15:0] a;} bbw_row_type;
  logic mclk_i = 0, rstn_i = 0, ce_i = 1, pay_pwr_i = 0, host_cfg_i = 0, hev_valid_i = 0;
  logic log_mode_i = 0, done = 0, host_stop_i, fl_ready_i;
  logic [1:0] host_act_i = 0;
  logic [2:0] host_use_i = 0, lat = 0;
  logic [7:0] hev_type_i = 0, hev_evt_i = 0, hev_num_i = 0;
  logic [23:0] hev_data_i = 0;
  logic bios_sel_o, sys_reset_o, running_o, fl_write_o, fl_erase_o, log_full_o, evr_valid_o;
  logic [7:0] secs_left_o;
  logic [1:0] action_o;
  logic [2:0] timer_use_o;
  logic [15:0] fl_addr_o;
  logic [127:0] fl_data_o, evr_data_o, rec;
  int mismatches = 0, num_checks = 0, i, j;
  bbw_row_type rows [4] = '{'{8'h23, 8'h6f, 8'h04, 24'h010000, 16'h0000},
    '{8'hc0, 8'h70, 8'h09, 24'ha00329, 16'h0010}, '{8'hc0, 8'h70, 8'h09, 24'ha00331, 16'h0020},
    '{8'h12, 8'h34, 8'h56, 24'hffffff, 16'h0030}};

  initial forever #20 mclk_i = ~mclk_i;
  bbw_watchdog i_dut (.mclk_i, .rstn_i, .ce_i, .pay_pwr_i, .host_stop_i, .host_cfg_i,
    .host_act_i, .host_use_i, .hev_valid_i, .hev_type_i, .hev_evt_i, .hev_num_i, .hev_data_i,
    .log_mode_i, .fl_ready_i, .bios_sel_o, .sys_reset_o, .running_o, .secs_left_o, .action_o,
    .timer_use_o, .fl_write_o, .fl_erase_o, .fl_addr_o, .fl_data_o, .log_full_o, .evr_valid_o,
    .evr_data_o);
  bbw_host_model i_host (.mclk_i, .rstn_i, .lat_i(lat), .boot_done_i(done),
    .fl_write_i(fl_write_o), .fl_ready_o(fl_ready_i), .host_stop_o(host_stop_i));

  task automatic chk(input logic [127:0] s, input logic [127:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, s, e);
    end
  endtask : chk

  task automatic send(input bbw_row_type r);
    {hev_type_i, hev_evt_i, hev_num_i, hev_data_i} = {r.t, r.e, r.n, r.d};
    rec = {r.t, r.e, r.n, r.d, 80'h0};
    hev_valid_i = 1;
    @(negedge mclk_i);
    hev_valid_i = 0;
  endtask : send

  task automatic drain();
    for (j = 0; j < 12 && fl_write_o; j++) @(negedge mclk_i);
    chk(fl_write_o, 0);
  endtask : drain

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  initial begin
    repeat (2) @(negedge mclk_i);
    rstn_i = 1;
    chk(bios_sel_o, 0);
    chk(action_o, ACT_HARD_RESET);
    chk(timer_use_o, USE_BIOS);
    pay_pwr_i = 1;
    repeat (3) @(negedge mclk_i);
    chk(running_o, 1);
    chk(secs_left_o, BOOT_TIMEOUT_S);
    chk(sys_reset_o, 0);
    chk(log_full_o, 0);
    for (i = 0; i < 4; i++) begin
      host_act_i = 2'(i);
      host_use_i = i[0] ? USE_OS : USE_BIOS;
      host_cfg_i = 1;
      @(negedge mclk_i);
      host_cfg_i = 0;
      chk(action_o, host_act_i);
      chk(timer_use_o, host_use_i);
    end
    lat = 2;
    for (i = 0; i < 4; i++) begin
      send(rows[i]);
      chk(evr_valid_o, 1);
      chk(evr_data_o, rec);
      chk(fl_write_o, 1);
      chk(fl_addr_o, rows[i].a);
      chk(fl_data_o, rec);
      drain();
    end
    // second event lands while the writer is busy: receiver gets both, log only one
    lat = 4;
    hev_valid_i = 1;
    @(negedge mclk_i);
    chk(fl_addr_o, 16'h0040);
    @(negedge mclk_i);
    hev_valid_i = 0;
    chk(evr_valid_o, 1);
    chk(fl_addr_o, 16'h0040);
    drain();
    log_mode_i = 1;
    @(negedge mclk_i);
    chk(fl_erase_o, 1);
    @(negedge mclk_i);
    send(rows[3]);
    chk(fl_addr_o, 16'h0000);
    drain();
    done = 1;
    @(negedge mclk_i);
    done = 0;
    for (j = 0; j < 4 && running_o; j++) @(negedge mclk_i);
    chk(running_o, 0);
    pay_pwr_i = 0;
    repeat (4) @(negedge mclk_i);
    pay_pwr_i = 1;
    repeat (3) @(negedge mclk_i);
    chk(secs_left_o, BOOT_TIMEOUT_S);
    chk(bios_sel_o, 0);
    rstn_i = 0;
    @(negedge mclk_i);
    chk(action_o, ACT_HARD_RESET);
    rstn_i = 1;
    @(negedge mclk_i);
    final_report();
  end

  initial begin
    repeat (2000) @(posedge mclk_i);
    mismatches++;
    final_report();
  end
endmodule : testbench
